/* File: hdl/ptc_pkg.sv */
/*
  Constants shared by the periodic timer core: register byte offsets,
  field positions, reset values, mode and clock-select codes.
  Assumes a 32-bit APB with byte addresses and registers in the low lane.
*/
package ptc_pkg;
  localparam int CNT_W  = 10;
  localparam int REG_W  = 8;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int IRQ_W  = 3;

  localparam logic [APB_AW-1:0] OFF_CTRL0   = 8'h00;
  localparam logic [APB_AW-1:0] OFF_CTRL1   = 8'h04;
  localparam logic [APB_AW-1:0] OFF_CNT_L   = 8'h08;
  localparam logic [APB_AW-1:0] OFF_CNT_H   = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_CMPA_L  = 8'h10;
  localparam logic [APB_AW-1:0] OFF_CMPA_H  = 8'h14;
  localparam logic [APB_AW-1:0] OFF_CMPP_L  = 8'h18;
  localparam logic [APB_AW-1:0] OFF_CMPP_H  = 8'h1C;
  localparam logic [APB_AW-1:0] OFF_IRQ_STS = 8'h20;
  localparam logic [APB_AW-1:0] OFF_IRQ_CLR = 8'h24;
  localparam logic [APB_AW-1:0] OFF_IRQ_EN  = 8'h28;

  localparam logic [REG_W-1:0] CTRL0_MASK = 8'hF8;
  localparam logic [REG_W-1:0] REG_RST    = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST    = 10'h000;
  localparam logic [CNT_W-1:0] CNT_MAX    = 10'h3FF;
  localparam logic [CNT_W-1:0] CNT_ONE    = 10'h001;
  localparam logic [IRQ_W-1:0] IRQ_RST    = 3'h0;

  localparam int C0_PAUSE  = 7;
  localparam int C0_CK_HI  = 6;
  localparam int C0_CK_LO  = 4;
  localparam int C0_RUN    = 3;
  localparam int C1_MD_HI  = 7;
  localparam int C1_MD_LO  = 6;
  localparam int C1_IO_HI  = 5;
  localparam int C1_IO_LO  = 4;
  localparam int C1_OC     = 3;
  localparam int C1_POL    = 2;
  localparam int C1_CCLR   = 0;
  localparam int HI_MSB    = 1;

  localparam int IRQ_OVF = 0;
  localparam int IRQ_MA  = 1;
  localparam int IRQ_MP  = 2;

  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;

  localparam logic [1:0] IO_NONE = 2'h0;
  localparam logic [1:0] IO_LOW  = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOG  = 2'h3;

  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS  = 3'h1;
  localparam logic [2:0] CK_FH16 = 3'h2;
  localparam logic [2:0] CK_FH64 = 3'h3;
  localparam logic [2:0] CK_TBC  = 3'h4;
  localparam logic [2:0] CK_FH   = 3'h5;
  localparam logic [2:0] CK_PINR = 3'h6;
  localparam logic [2:0] CK_PINF = 3'h7;

  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [1:0] DIV4_ONE  = 2'h1;
  localparam logic [5:0] FH_ONE    = 6'h01;
  localparam logic [5:0] FH16_MASK = 6'h0F;
  localparam logic [5:0] FH64_MASK = 6'h3F;
endpackage

/* File: hdl/ptc_core.sv */
/*
  Periodic timer core: 10-bit up-counter with selectable count clock,
  comparators A and P, run/pause control, compare output pin, sticky
  interrupt flags and an APB register slave.
  Assumes clk is the system clock; the fast clock, timebase clock and
  external count pin are asynchronous and are only sampled here.
*/
// Functional notes
// - The count is 10 bits and rises by one on each active edge of the chosen count clock.
// - Comparators A and P compare the full count against their 10-bit values on every count.
// - Software cannot write the count; a 0-to-1 change of run clears it to zero.
// - Overflow or a match on the selected clearing comparator clears the count.
// - A clearing overflow or match also raises an interrupt flag.
// - The count reads as a low byte (bits 7..0) and a high byte (bits 9..8 in bits 1..0).
// - Unimplemented bits read as zero and ignore writes, except ctrl1 bit 1, which has no function but stores and reads back.
// - Compare value A sits in a read/write low and high register pair.
// - Compare value P sits in a read/write low and high register pair.
// - While pause is set the count holds and later resumes from the held value.
// - The 3-bit clock field picks one of eight count clocks.
// - Run starts counting; clearing it stops the count, which keeps its value.
// - In compare output mode a run rise returns the pin to its initial level.
// - The 2-bit mode field picks compare, capture, PWM or timer; timer mode disables the pin.
module ptc_core (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ptc_pkg::APB_AW-1:0]  paddr,
  input  wire logic [ptc_pkg::APB_DW-1:0]  pwdata,
  output logic      [ptc_pkg::APB_DW-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Asynchronous clock sources
  input  wire logic                        fast_internal_clock,
  input  wire logic                        timebase_clock,
  input  wire logic                        external_count_pin,
  // Timer output pin
  output logic                             timer_io_pin_o,
  output logic                             timer_io_pin_oe,
  // Interrupt
  output logic                             irq
);
  logic [ptc_pkg::REG_W-1:0]  ctrl0_ff;
  logic [ptc_pkg::REG_W-1:0]  ctrl1_ff;
  logic [ptc_pkg::CNT_W-1:0]  cmpa_ff;
  logic [ptc_pkg::CNT_W-1:0]  cmpp_ff;
  logic [ptc_pkg::CNT_W-1:0]  cnt_ff;
  logic [ptc_pkg::IRQ_W-1:0]  sts_ff;
  logic [ptc_pkg::IRQ_W-1:0]  en_ff;
  logic [ptc_pkg::APB_DW-1:0] prdata_ff;
  logic                       run_d_ff;
  logic                       out_ff;
  logic [2:0]                 sync1_ff;
  logic [2:0]                 sync2_ff;
  logic [2:0]                 sync3_ff;
  logic [1:0]                 div4_ff;
  logic [5:0]                 fhdiv_ff;
  logic [ptc_pkg::APB_DW-1:0] nxt_prdata;
  logic [ptc_pkg::IRQ_W-1:0]  nxt_sts;
  logic [ptc_pkg::IRQ_W-1:0]  evt;
  logic [ptc_pkg::IRQ_W-1:0]  clr_mask;
  logic [ptc_pkg::REG_W-1:0]  wbyte;
  logic                       mapped;
  logic                       wr_en;
  logic                       rd_setup;
  logic                       run;
  logic                       pause;
  logic [2:0]                 ck_sel;
  logic [1:0]                 mode;
  logic [1:0]                 io_sel;
  logic                       run_rise;
  logic                       tick;
  logic                       cnt_en;
  logic                       match_a;
  logic                       match_p;
  logic                       ovf;
  logic                       clr_by_a;
  logic                       clear_hit;
  logic                       fh_rise;
  logic                       tbc_rise;
  logic                       pin_rise;
  logic                       pin_fall;

  assign run    = ctrl0_ff[ptc_pkg::C0_RUN];
  assign pause  = ctrl0_ff[ptc_pkg::C0_PAUSE];
  assign ck_sel = ctrl0_ff[ptc_pkg::C0_CK_HI:ptc_pkg::C0_CK_LO];
  assign mode   = ctrl1_ff[ptc_pkg::C1_MD_HI:ptc_pkg::C1_MD_LO];
  assign io_sel = ctrl1_ff[ptc_pkg::C1_IO_HI:ptc_pkg::C1_IO_LO];
  assign wbyte  = pwdata[ptc_pkg::REG_W-1:0];

  // APB decode: zero wait states, error on unmapped addresses
  always_comb begin
    unique case (paddr)
      ptc_pkg::OFF_CTRL0, ptc_pkg::OFF_CTRL1, ptc_pkg::OFF_CNT_L,
      ptc_pkg::OFF_CNT_H, ptc_pkg::OFF_CMPA_L, ptc_pkg::OFF_CMPA_H,
      ptc_pkg::OFF_CMPP_L, ptc_pkg::OFF_CMPP_H, ptc_pkg::OFF_IRQ_STS,
      ptc_pkg::OFF_IRQ_CLR, ptc_pkg::OFF_IRQ_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign wr_en    = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign prdata   = prdata_ff;

  // Read data is latched in the setup cycle so it comes from a flop
  always_comb begin
    nxt_prdata = '0;
    unique case (paddr)
      ptc_pkg::OFF_CTRL0:   nxt_prdata[ptc_pkg::REG_W-1:0] = ctrl0_ff;
      ptc_pkg::OFF_CTRL1:   nxt_prdata[ptc_pkg::REG_W-1:0] = ctrl1_ff;
      ptc_pkg::OFF_CNT_L:   nxt_prdata[ptc_pkg::REG_W-1:0] = cnt_ff[ptc_pkg::REG_W-1:0];
      ptc_pkg::OFF_CNT_H:   nxt_prdata[ptc_pkg::HI_MSB:0] = cnt_ff[ptc_pkg::CNT_W-1:ptc_pkg::REG_W];
      ptc_pkg::OFF_CMPA_L:  nxt_prdata[ptc_pkg::REG_W-1:0] = cmpa_ff[ptc_pkg::REG_W-1:0];
      ptc_pkg::OFF_CMPA_H:  nxt_prdata[ptc_pkg::HI_MSB:0] = cmpa_ff[ptc_pkg::CNT_W-1:ptc_pkg::REG_W];
      ptc_pkg::OFF_CMPP_L:  nxt_prdata[ptc_pkg::REG_W-1:0] = cmpp_ff[ptc_pkg::REG_W-1:0];
      ptc_pkg::OFF_CMPP_H:  nxt_prdata[ptc_pkg::HI_MSB:0] = cmpp_ff[ptc_pkg::CNT_W-1:ptc_pkg::REG_W];
      ptc_pkg::OFF_IRQ_STS: nxt_prdata[ptc_pkg::IRQ_W-1:0] = sts_ff;
      ptc_pkg::OFF_IRQ_EN:  nxt_prdata[ptc_pkg::IRQ_W-1:0] = en_ff;
      default:              nxt_prdata = '0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_ff <= '0;
    end else if (rd_setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Control and compare registers; count has no write path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0_ff <= ptc_pkg::REG_RST;
      ctrl1_ff <= ptc_pkg::REG_RST;
      cmpa_ff  <= ptc_pkg::CNT_RST;
      cmpp_ff  <= ptc_pkg::CNT_RST;
      en_ff    <= ptc_pkg::IRQ_RST;
    end else if (wr_en) begin
      unique case (paddr)
        ptc_pkg::OFF_CTRL0:  ctrl0_ff <= wbyte & ptc_pkg::CTRL0_MASK;
        ptc_pkg::OFF_CTRL1:  ctrl1_ff <= wbyte;
        ptc_pkg::OFF_CMPA_L: cmpa_ff[ptc_pkg::REG_W-1:0] <= wbyte;
        ptc_pkg::OFF_CMPA_H: cmpa_ff[ptc_pkg::CNT_W-1:ptc_pkg::REG_W] <= wbyte[ptc_pkg::HI_MSB:0];
        ptc_pkg::OFF_CMPP_L: cmpp_ff[ptc_pkg::REG_W-1:0] <= wbyte;
        ptc_pkg::OFF_CMPP_H: cmpp_ff[ptc_pkg::CNT_W-1:ptc_pkg::REG_W] <= wbyte[ptc_pkg::HI_MSB:0];
        ptc_pkg::OFF_IRQ_EN: en_ff <= wbyte[ptc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Two-flop synchronisers, third stage only for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= {external_count_pin, timebase_clock, fast_internal_clock};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign fh_rise  = sync2_ff[0] & ~sync3_ff[0];
  assign tbc_rise = sync2_ff[1] & ~sync3_ff[1];
  assign pin_rise = sync2_ff[2] & ~sync3_ff[2];
  assign pin_fall = ~sync2_ff[2] & sync3_ff[2];

  // Prescalers run free so a clock change never waits for a restart
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div4_ff  <= '0;
      fhdiv_ff <= '0;
    end else begin
      div4_ff <= div4_ff + ptc_pkg::DIV4_ONE;
      if (fh_rise) begin
        fhdiv_ff <= fhdiv_ff + ptc_pkg::FH_ONE;
      end
    end
  end

  // Sampled clocks must stay well below half of clk to be seen
  always_comb begin
    unique case (ck_sel)
      ptc_pkg::CK_SYS4: tick = (div4_ff == ptc_pkg::DIV4_LAST);
      ptc_pkg::CK_SYS:  tick = 1'b1;
      ptc_pkg::CK_FH16: tick = fh_rise & ((fhdiv_ff & ptc_pkg::FH16_MASK) == ptc_pkg::FH16_MASK);
      ptc_pkg::CK_FH64: tick = fh_rise & (fhdiv_ff == ptc_pkg::FH64_MASK);
      ptc_pkg::CK_TBC:  tick = tbc_rise;
      ptc_pkg::CK_FH:   tick = fh_rise;
      ptc_pkg::CK_PINR: tick = pin_rise;
      ptc_pkg::CK_PINF: tick = pin_fall;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_d_ff <= 1'b0;
    end else begin
      run_d_ff <= run;
    end
  end

  assign run_rise = run & ~run_d_ff;
  assign cnt_en   = run & ~pause & tick & ~run_rise;
  assign match_a  = cnt_en & (cnt_ff == cmpa_ff);
  assign match_p  = cnt_en & (cnt_ff == cmpp_ff);
  assign ovf      = cnt_en & (cnt_ff == ptc_pkg::CNT_MAX);
  // Capture and PWM periods always come from comparator P
  assign clr_by_a  = ctrl1_ff[ptc_pkg::C1_CCLR] & ((mode == ptc_pkg::MODE_CMP) | (mode == ptc_pkg::MODE_TMR));
  assign clear_hit = ovf | (clr_by_a ? match_a : match_p);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= ptc_pkg::CNT_RST;
    end else if (run_rise) begin
      cnt_ff <= ptc_pkg::CNT_RST;
    end else if (cnt_en) begin
      if (clear_hit) begin
        cnt_ff <= ptc_pkg::CNT_RST;
      end else begin
        cnt_ff <= cnt_ff + ptc_pkg::CNT_ONE;
      end
    end
  end

  // Compare output; level before polarity
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_ff <= 1'b0;
    end else if (mode == ptc_pkg::MODE_CMP) begin
      if (run_rise) begin
        out_ff <= ctrl1_ff[ptc_pkg::C1_OC];
      end else if (match_a) begin
        unique case (io_sel)
          ptc_pkg::IO_NONE: out_ff <= out_ff;
          ptc_pkg::IO_LOW:  out_ff <= 1'b0;
          ptc_pkg::IO_HIGH: out_ff <= 1'b1;
          ptc_pkg::IO_TOG:  out_ff <= ~out_ff;
        endcase
      end
    end
  end

  assign timer_io_pin_o  = out_ff ^ ctrl1_ff[ptc_pkg::C1_POL];
  assign timer_io_pin_oe = (mode != ptc_pkg::MODE_TMR);

  // Sticky flags; a new event wins over a clear in the same cycle
  assign evt      = {match_p, match_a, ovf};
  assign clr_mask = (wr_en && paddr == ptc_pkg::OFF_IRQ_CLR) ? wbyte[ptc_pkg::IRQ_W-1:0] : ptc_pkg::IRQ_RST;
  assign nxt_sts  = (sts_ff & ~clr_mask) | evt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sts_ff <= ptc_pkg::IRQ_RST;
    end else begin
      sts_ff <= nxt_sts;
    end
  end

  assign irq = |(sts_ff & en_ff);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_RUN_CLEAR: assert property (run_rise |=> cnt_ff == ptc_pkg::CNT_RST)
    else $error("count not cleared on run rise");
  AST_INCREMENT: assert property (cnt_en && !clear_hit |=> cnt_ff == $past(cnt_ff) + ptc_pkg::CNT_ONE)
    else $error("count did not step by one");
  AST_PAUSE_HOLD: assert property (run && pause && !run_rise |=> $stable(cnt_ff))
    else $error("count moved while paused");
  AST_OFF_HOLD: assert property (!run ##1 !run |-> $stable(cnt_ff))
    else $error("count moved while off");
  AST_WRAP: assert property (ovf |=> cnt_ff == ptc_pkg::CNT_RST && sts_ff[ptc_pkg::IRQ_OVF])
    else $error("no wrap or overflow flag");
  AST_MATCH_CLEAR: assert property (cnt_en && (clr_by_a ? match_a : match_p) |=> cnt_ff == ptc_pkg::CNT_RST)
    else $error("match did not clear count");
  AST_FLAG_SET: assert property (match_a |=> sts_ff[ptc_pkg::IRQ_MA])
    else $error("match flag not raised");
  AST_HIGH_ZERO: assert property (rd_setup && paddr == ptc_pkg::OFF_CNT_H |=> prdata[ptc_pkg::APB_DW-1:2] == '0)
    else $error("unimplemented bits not zero");
  AST_CNT_READ: assert property (rd_setup && paddr == ptc_pkg::OFF_CNT_L |=> prdata[ptc_pkg::REG_W-1:0] == $past(cnt_ff[ptc_pkg::REG_W-1:0]))
    else $error("count low read mismatch");
  AST_OUT_INIT: assert property (run_rise && mode == ptc_pkg::MODE_CMP |=> out_ff == $past(ctrl1_ff[ptc_pkg::C1_OC]))
    else $error("pin not at initial level");
  AST_PIN_OFF: assert property (mode == ptc_pkg::MODE_TMR |-> !timer_io_pin_oe)
    else $error("pin driven in timer mode");

  COV_OVERFLOW: cover property (ovf);
  COV_MATCH_A:  cover property (match_a && clr_by_a);
  COV_MATCH_P:  cover property (match_p && !clr_by_a);
  COV_IRQ:      cover property (irq);
endmodule

/* File: verif/ptc_core_tb_top.sv */
/*
  Self-checking bench for the periodic timer core: APB master task, a cycle
  model of counter, compare values, flags and registers, and directed checks.
  Assumes ptc_pkg and ptc_core are compiled first and a zero-wait APB slave.
*/
module ptc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, psel, penable, pwrite, fclk, tbclk, xpin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ex;
  logic        pready, pslverr, pin_o, pin_oe, irq;
  logic [9:0]  m_cnt, m_a, m_p;
  logic [7:0]  m_c0, m_c1;
  logic [2:0]  m_sts, m_en, m_evt;
  logic        m_runp;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          seed, k;
  int          exp_sel[8] = '{0, 0, 4, 1, 64, 64, 64, 64};
  wire         wr_done = psel & penable & pwrite & pready;
  // A step happens only on the system-clock select, never in the cycle that run rises
  wire         m_step = m_c0[3] && m_runp && !m_c0[7] && m_c0[6:4] == ptc_pkg::CK_SYS;
  assign m_evt = {3{m_step}} & {m_cnt == m_p, m_cnt == m_a, m_cnt == 10'h3FF};

  ptc_core i_ptc_core (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_internal_clock(fclk), .timebase_clock(tbclk), .external_count_pin(xpin),
    .timer_io_pin_o(pin_o), .timer_io_pin_oe(pin_oe), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Model follows bus writes; it steps only on the system-clock select
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {m_cnt, m_a, m_p, m_c0, m_c1, m_sts, m_en, m_runp} <= '0;
    end else begin
      m_runp <= m_c0[3];
      if (m_c0[3] && !m_runp) begin
        m_cnt <= 10'h000;
      end else if (m_step) begin
        if (m_cnt == 10'h3FF || m_cnt == (m_c1[0] ? m_a : m_p)) m_cnt <= 10'h000;
        else m_cnt <= m_cnt + 10'h001;
      end
      // A flag raised in the same cycle as its clear survives
      m_sts <= m_sts & ~((wr_done && paddr == ptc_pkg::OFF_IRQ_CLR) ? pwdata[2:0] : 3'h0) | m_evt;
      if (wr_done) begin
        case (paddr)
          ptc_pkg::OFF_CTRL0:  m_c0 <= pwdata[7:0] & ptc_pkg::CTRL0_MASK;
          ptc_pkg::OFF_CTRL1:  m_c1 <= pwdata[7:0];
          ptc_pkg::OFF_CMPA_L: m_a[7:0] <= pwdata[7:0];
          ptc_pkg::OFF_CMPA_H: m_a[9:8] <= pwdata[1:0];
          ptc_pkg::OFF_CMPP_L: m_p[7:0] <= pwdata[7:0];
          ptc_pkg::OFF_CMPP_H: m_p[9:8] <= pwdata[1:0];
          ptc_pkg::OFF_IRQ_EN: m_en <= pwdata[2:0];
          default: ;
        endcase
      end
    end
  end

  function automatic logic [31:0] exp_rd(input logic [7:0] ad);
    case (ad)
      ptc_pkg::OFF_CTRL0:   return {24'h0, m_c0};
      ptc_pkg::OFF_CTRL1:   return {24'h0, m_c1};
      ptc_pkg::OFF_CNT_L:   return {24'h0, m_cnt[7:0]};
      ptc_pkg::OFF_CNT_H:   return {30'h0, m_cnt[9:8]};
      ptc_pkg::OFF_CMPA_L:  return {24'h0, m_a[7:0]};
      ptc_pkg::OFF_CMPA_H:  return {30'h0, m_a[9:8]};
      ptc_pkg::OFF_CMPP_L:  return {24'h0, m_p[7:0]};
      ptc_pkg::OFF_CMPP_H:  return {30'h0, m_p[9:8]};
      ptc_pkg::OFF_IRQ_STS: return {29'h0, m_sts};
      ptc_pkg::OFF_IRQ_EN:  return {29'h0, m_en};
      default:              return 32'h0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Expected read data is taken when the setup phase is driven, as the slave latches it then
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd, input logic cmp);
    int t;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    #1;
    ex = exp_rd(ad);
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 100);
    rd = prdata;
    chk({31'h0, pready}, 32'h1);
    chk({31'h0, pslverr}, {31'h0, !(ad <= 8'h28 && ad[1:0] == 2'h0)});
    if (cmp && !wr) chk(rd, ex);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      {fclk, tbclk, xpin} <= 3'h7;
      repeat (4) @(posedge clk);
      {fclk, tbclk, xpin} <= 3'h0;
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    {psel, penable, pwrite, fclk, tbclk, xpin} = '0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    arst_n = 1'b0;
    seed   = 63;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (k = 0; k < 12; k++) xfer(1'b0, 8'(4 * k), 32'h0, 1'b1);
    // Run bit kept low so random control values never start the counter
    repeat (3) begin
      for (k = 0; k < 14; k++) begin
        xfer(1'b1, 8'(4 * k), 32'($random(seed)) & 32'hFFFF_FFF7, 1'b0);
        xfer(1'b0, 8'(4 * k), 32'h0, 1'b1);
      end
    end
    for (k = 0; k < 4; k++) begin
      xfer(1'b1, ptc_pkg::OFF_CTRL1, 32'(k * 64), 1'b0);
      #2;
      chk({31'h0, pin_oe}, {31'h0, k != 3});
    end
    xfer(1'b1, ptc_pkg::OFF_CMPP_L, 32'(3 + ($random(seed) & 31)), 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CMPP_H, 32'h0, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CMPA_L, 32'h2, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CMPA_H, 32'h0, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CTRL1, 32'hC0, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_IRQ_EN, 32'h7, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h0, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h18, 1'b0);
    repeat (20 + ($random(seed) & 63)) @(posedge clk);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h98, 1'b0);
    xfer(1'b0, ptc_pkg::OFF_CNT_L, 32'h0, 1'b1);
    xfer(1'b0, ptc_pkg::OFF_IRQ_STS, 32'h0, 1'b1);
    #2;
    chk({31'h0, irq}, {31'h0, |(m_sts & m_en)});
    xfer(1'b1, ptc_pkg::OFF_IRQ_CLR, 32'h7, 1'b0);
    xfer(1'b0, ptc_pkg::OFF_IRQ_STS, 32'h0, 1'b1);
    #2;
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, ptc_pkg::OFF_IRQ_EN, 32'h0, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h18, 1'b0);
    repeat (30 + ($random(seed) & 63)) @(posedge clk);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h98, 1'b0);
    xfer(1'b0, ptc_pkg::OFF_CNT_L, 32'h0, 1'b1);
    xfer(1'b0, ptc_pkg::OFF_IRQ_STS, 32'h0, 1'b1);
    #2;
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h0, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CTRL1, 32'h18, 1'b0);
    // Period above the match point, so comparator A is reached before the clear
    xfer(1'b1, ptc_pkg::OFF_CMPP_L, 32'hFF, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CMPA_L, 32'h14, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h18, 1'b0);
    repeat (5) @(posedge clk);
    #2;
    chk({31'h0, pin_o}, 32'h1);
    repeat (40) @(posedge clk);
    #2;
    chk({31'h0, pin_o}, 32'h0);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h0, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h18, 1'b0);
    repeat (5) @(posedge clk);
    #2;
    chk({31'h0, pin_o}, 32'h1);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h0, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CTRL1, 32'hC1, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CMPA_L, 32'hFF, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CMPA_H, 32'h3, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_IRQ_EN, 32'h1, 1'b0);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h18, 1'b0);
    repeat (300 + ($random(seed) & 511)) @(posedge clk);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h98, 1'b0);
    xfer(1'b0, ptc_pkg::OFF_CNT_L, 32'h0, 1'b1);
    xfer(1'b0, ptc_pkg::OFF_CNT_H, 32'h0, 1'b1);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h18, 1'b0);
    repeat (1024) @(posedge clk);
    xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h98, 1'b0);
    xfer(1'b0, ptc_pkg::OFF_IRQ_STS, 32'h0, 1'b1);
    xfer(1'b0, ptc_pkg::OFF_CNT_L, 32'h0, 1'b1);
    #2;
    chk({31'h0, irq}, {31'h0, |(m_sts & m_en)});
    for (k = 0; k < 8; k++) begin
      if (k == 1) continue;
      xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'h0, 1'b0);
      xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'(k * 16 + 8), 1'b0);
      pulses(64);
      repeat (8) @(posedge clk);
      xfer(1'b1, ptc_pkg::OFF_CTRL0, 32'(k * 16 + 136), 1'b0);
      pulses(4);
      xfer(1'b0, ptc_pkg::OFF_CNT_L, 32'h0, 1'b0);
      if (k == 0) chk({31'h0, rd >= 126 && rd <= 134}, 32'h1);
      else chk(rd, 32'(exp_sel[k]));
    end
    conclude();
  end
endmodule
